// >>> src/fpu_csr_map.vh
`ifndef FPU_CSR_MAP_VH
`define FPU_CSR_MAP_VH
// ********************************
// register offsets (byte addresses)
// ********************************
`define OFS_CONFIG    8'h00
`define OFS_STATUS    8'h04
`define OFS_INDIRECT  8'h08
`define OFS_STACK0    8'h0c
`define OFS_STACK1    8'h10
`define OFS_VECTOR    8'h14
`define OFS_IRQ_RET   8'h18
`define OFS_EVENTS    8'h1c
`define OFS_OUTPUTS   8'h20
// ********************************
// reset values and fields
// ********************************
`define CONFIG_RESET   32'hffe00420
`define CONFIG_WMASK   32'hffe0037f
`define CONFIG_REV_BIT 10
`define ST_ED_BIT      18
`define ST_DETECT_IRQ_ENABLE_BIT 12
`define ST_WMASK       32'h0001b800
`define STK_PTR_BIT    31
`define STK_EN_BIT     30
`define SPACE_BIT      16
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10
`endif

// >>> src/fpu_control_status_regs.v
// Behaviour
// RQ1 - config bits 31..21 enable exceptions, reset one
// RQ2 - status bit 18 ORs enabled exceptions
// RQ3 - config 20..11 read zero; bit 7 zero
// RQ4 - bus_pin_config gates strobes by local_output_enable
// RQ5 - interrupt out follows move bit in independent mode
// RQ6 - memory_select_config picks chip enable scheme
// RQ7 - single_file_mode mirrors file writes
// RQ8 - bits 5,4 bypass output/pipeline registers
// RQ9 - flush_mode zeroes denormal inputs and results
// RQ10 - bit 2 selects 64-bit word order
// RQ11 - two rounding bits select rounding mode
// RQ12 - status clears; detect enable by mode
// RQ13 - compare flags in status 31..29,17,14,13
// RQ14 - IEEE flags 28..25, zero divisor 24
// RQ15 - rounding, denormal, port flags 23..19
// RQ16 - soft flag, irq enables, hard flag
// RQ17 - min/max flags in status 10..5
// RQ18 - indirect address clears; bit 16 selects space
// RQ19 - two-deep return stack, third push overwrites
// RQ20 - stack pointer bit 31, write needs bit 30
// RQ21 - vector clears, bit 16 reads low
// RQ22 - irq return captures pc, reset untouched
// RQ23 - configuration resets to fixed value
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`include "fpu_csr_map.vh"
module fpu_control_status_regs #(
	parameter [31:0] REVISION_ID = 32'h00000001 // arbitrary value
) (
	input  wire        clk_sys_i,
	input  wire        rst_i,
	input  wire        coproc_mode_i,
	// axi4-lite slave
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// core events, same clock
	input  wire [10:0] exc_raw_i,
	input  wire        status_upd_i,
	input  wire [31:0] status_core_i,
	input  wire        soft_irq_set_i,
	input  wire        hard_irq_set_i,
	input  wire        sub_push_i,
	input  wire        sub_pop_i,
	input  wire        irq_take_i,
	input  wire [16:0] pc_i,
	input  wire        move_bit1_i,
	input  wire        move_indirect_i,
	// pins
	input  wire        local_output_enable_i,
	input  wire        code_access_i,
	input  wire        mem_access_i,
	output reg         strobe_oe_o,
	output reg         local_bus_oe_o,
	output reg         coproc_interrupt_out_n_o,
	output reg         memory_chip_enable_n_o,
	output reg         space_select_o,
	output reg  [16:0] return_addr_o,
	output reg  [31:0] config_o,
	output reg         enabled_exception_any_o
);

	// ********************************
	// registers
	// ********************************
	reg  [31:0] cfg_reg;
	reg  [31:0] status_reg;
	reg  [31:0] indirect_address_reg;
	reg  [31:0] stk0_reg;
	reg  [31:0] stk1_reg;
	reg  [31:0] vector_reg;
	reg  [31:0] irq_return_addr_reg;
	reg  [7:0]  waddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	reg         aw_have_reg;
	reg         w_have_reg;
	reg         loe_s1_reg;
	reg         loe_s2_reg;

	// byte-lane merge, used for every writable register
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		input [31:0] wm;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 32; i = i + 1)
				if (st[i/8] && wm[i])
					merge[i] = nw[i];
		end
	endfunction

	// pointer bit joins the write mask only when the enable bit comes along
	function [31:0] stack_wmask;
		input [31:0] d;
		begin
			stack_wmask = {d[`STK_EN_BIT], 31'h7fffffff}; // RQ20
		end
	endfunction

	// entry pushed by a call: pointer set, return address in the low bits
	function [31:0] stack_word;
		input [16:0] pc;
		begin
			stack_word = {1'b1, 14'h0000, pc}; // RQ19
		end
	endfunction

	// ********************************
	// write channel
	// ********************************
	wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
	wire wr_cfg   = do_write && waddr_reg == `OFS_CONFIG;
	wire wr_st    = do_write && waddr_reg == `OFS_STATUS;
	wire wr_ind   = do_write && waddr_reg == `OFS_INDIRECT;
	wire wr_s0    = do_write && waddr_reg == `OFS_STACK0;
	wire wr_s1    = do_write && waddr_reg == `OFS_STACK1;
	wire wr_vec   = do_write && waddr_reg == `OFS_VECTOR;
	wire wr_ira   = do_write && waddr_reg == `OFS_IRQ_RET;
	wire wr_ok    = wr_cfg | wr_st | wr_ind | wr_s0 | wr_s1 | wr_vec | wr_ira;

	// address and data taken in either order, answer after both
	// readies stay low until the response is taken, so one write at a time
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			aw_have_reg     <= 1'b0;
			w_have_reg      <= 1'b0;
			waddr_reg       <= 8'h00;
			wdata_reg       <= 32'h00000000;
			wstrb_reg       <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_have_reg     <= 1'b1;
				waddr_reg       <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_have_reg     <= 1'b1;
				wdata_reg      <= s_axi_wdata_i;
				wstrb_reg      <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
				aw_have_reg    <= 1'b0;
				w_have_reg     <= 1'b0;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	// ********************************
	// configuration register
	// ********************************
	// read-only and reserved bits are kept out by the write mask
	// bit 7 is never stored, so a stray one from software is harmless
	always @(posedge clk_sys_i) begin
		if (rst_i)
			cfg_reg <= `CONFIG_RESET; // RQ23 RQ1 RQ8
		else if (wr_cfg)
			cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg, `CONFIG_WMASK); // RQ3
	end

	// read view: 20..11 and 7 forced zero, revision from parameter
	wire [31:0] cfg_view = {cfg_reg[31:21], 10'h000, REVISION_ID[0], cfg_reg[9:8],
		1'b0, cfg_reg[6:0]}; // RQ3

	// ********************************
	// status register
	// ********************************
	// enabled exceptions OR-ed into the detect flag
	wire ed_now = |(exc_raw_i & cfg_reg[31:21]); // RQ1 RQ2

	// core flags replace compare/ieee/minmax fields; software owns the enables.
	// a hardware set in the same cycle as a software clear wins.
	// the detect enable comes out of reset as the mode strap says
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			status_reg                  <= 32'h00000000; // RQ12
			status_reg[`ST_DETECT_IRQ_ENABLE_BIT] <= coproc_mode_i; // RQ12
		end else begin
			if (wr_st)
				status_reg <= merge(status_reg, wdata_reg, wstrb_reg, `ST_WMASK); // RQ16
			if (status_upd_i) begin
				status_reg[31:19] <= status_core_i[31:19]; // RQ13 RQ14 RQ15
				status_reg[17]    <= status_core_i[17]; // RQ13
				status_reg[14:13] <= status_core_i[14:13]; // RQ13
				status_reg[10:5]  <= status_core_i[10:5]; // RQ17
			end
			status_reg[`ST_ED_BIT] <= ed_now; // RQ2
			if (soft_irq_set_i)
				status_reg[16] <= 1'b1; // RQ16
			if (hard_irq_set_i)
				status_reg[4] <= 1'b1; // RQ16
		end
	end

	// bits 3..0 are reserved and read zero
	wire [31:0] st_view = {status_reg[31:4], 4'h0};

	// ********************************
	// address, stack, vector, return registers
	// ********************************
	// entry0 is top only while its pointer is set
	wire s0_top = stk0_reg[`STK_PTR_BIT];
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			indirect_address_reg <= 32'h00000000; // RQ18
			stk0_reg             <= 32'h00000000; // RQ20
			stk1_reg             <= 32'h00000000; // RQ20
			vector_reg           <= 32'h00000000; // RQ21
		end else begin
			if (wr_ind)
				indirect_address_reg <= merge(indirect_address_reg, wdata_reg, wstrb_reg,
					32'hffffffff);
			if (wr_vec)
				vector_reg <= merge(vector_reg, wdata_reg, wstrb_reg, 32'hfffeffff); // RQ21
			// pointer bit writable only with the enable bit set
			if (wr_s0)
				stk0_reg <= merge(stk0_reg, wdata_reg, wstrb_reg,
					stack_wmask(wdata_reg)); // RQ20
			if (wr_s1)
				stk1_reg <= merge(stk1_reg, wdata_reg, wstrb_reg,
					stack_wmask(wdata_reg)); // RQ20
			if (sub_push_i) begin
				// push to entry0 while both pointers are clear, otherwise to entry1
				if (!s0_top && !stk1_reg[`STK_PTR_BIT]) begin
					stk0_reg <= stack_word(pc_i); // RQ19
				end else begin
					stk1_reg <= stack_word(pc_i); // RQ19
					stk0_reg[`STK_PTR_BIT] <= 1'b0; // RQ20
				end
			end else if (sub_pop_i) begin
				if (stk1_reg[`STK_PTR_BIT]) begin
					stk1_reg[`STK_PTR_BIT] <= 1'b0; // RQ19
					stk0_reg[`STK_PTR_BIT] <= 1'b1;
				end else
					stk0_reg[`STK_PTR_BIT] <= 1'b0;
			end
		end
	end

	// not reset on purpose: the saved address must survive a reset
	// software may still load it when restoring a saved context
	always @(posedge clk_sys_i) begin
		if (irq_take_i)
			irq_return_addr_reg <= {15'h0000, pc_i}; // RQ22
		else if (wr_ira)
			irq_return_addr_reg <= merge(irq_return_addr_reg, wdata_reg, wstrb_reg,
				32'hffffffff);
	end

	// ********************************
	// read channel
	// ********************************
	// arready stays low until the data is taken: one read at a time
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h00000000;
			s_axi_rresp_o   <= `RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= `RESP_OKAY;
			case (s_axi_araddr_i)
				`OFS_CONFIG:   s_axi_rdata_o <= cfg_view;
				`OFS_STATUS:   s_axi_rdata_o <= st_view;
				`OFS_INDIRECT: s_axi_rdata_o <= indirect_address_reg;
				`OFS_STACK0:   s_axi_rdata_o <= stk0_reg;
				`OFS_STACK1:   s_axi_rdata_o <= stk1_reg;
				`OFS_VECTOR:   s_axi_rdata_o <= vector_reg & 32'hfffeffff; // RQ21
				`OFS_IRQ_RET:  s_axi_rdata_o <= irq_return_addr_reg;
				default: begin
					s_axi_rdata_o <= 32'h00000000;
					s_axi_rresp_o <= `RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

	// ********************************
	// pin control
	// ********************************
	// pin level synchroniser
	// the enable pin is not on this clock; only the second stage is used
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			loe_s1_reg <= 1'b0;
			loe_s2_reg <= 1'b0;
		end else begin
			loe_s1_reg <= local_output_enable_i;
			loe_s2_reg <= loe_s1_reg;
		end
	end

	// an indirect move takes its space from the address register
	wire pin_cfg = cfg_reg[9];
	wire mem_cfg = cfg_reg[8];
	wire cs_data = move_indirect_i ? indirect_address_reg[`SPACE_BIT] : !code_access_i;

	// all pin outputs registered; the active-low enable pin tri-states when high
	always @(posedge clk_sys_i) begin
		if (rst_i) begin
			strobe_oe_o              <= 1'b1;
			local_bus_oe_o           <= 1'b1;
			coproc_interrupt_out_n_o <= 1'b1;
			memory_chip_enable_n_o   <= 1'b1;
			space_select_o           <= 1'b0;
			return_addr_o            <= 17'h00000;
			config_o                 <= `CONFIG_RESET;
			enabled_exception_any_o  <= 1'b0;
		end else begin
			strobe_oe_o    <= !(pin_cfg && loe_s2_reg); // RQ4
			local_bus_oe_o <= !(pin_cfg && loe_s2_reg); // RQ4
			if (!coproc_mode_i && pin_cfg)
				coproc_interrupt_out_n_o <= !move_bit1_i; // RQ5
			else
				coproc_interrupt_out_n_o <= !(status_reg[`ST_ED_BIT] &&
					status_reg[`ST_DETECT_IRQ_ENABLE_BIT]);
			if (mem_cfg) begin
				memory_chip_enable_n_o <= !(mem_access_i && !cs_data); // RQ6
				space_select_o         <= !(mem_access_i && cs_data); // RQ6
			end else begin
				memory_chip_enable_n_o <= !mem_access_i; // RQ6
				space_select_o         <= cs_data; // RQ6
			end
			// a pop shows the entry it removes, otherwise the interrupt return
			if (sub_pop_i && stk1_reg[`STK_PTR_BIT])
				return_addr_o <= stk1_reg[16:0]; // RQ19
			else if (sub_pop_i)
				return_addr_o <= stk0_reg[16:0]; // RQ19
			else
				return_addr_o <= irq_return_addr_reg[16:0]; // RQ22
			// config fields steer the core and the pins
			config_o[31:21]         <= cfg_view[31:21]; // RQ1
			config_o[20:10]         <= cfg_view[20:10]; // RQ3
			config_o[9:7]           <= cfg_view[9:7]; // RQ4 RQ6
			config_o[6]             <= cfg_view[6]; // RQ7
			config_o[5:4]           <= cfg_view[5:4]; // RQ8
			config_o[3]             <= cfg_view[3]; // RQ9
			config_o[2]             <= cfg_view[2]; // RQ10
			config_o[1:0]           <= cfg_view[1:0]; // RQ11
			enabled_exception_any_o <= ed_now; // RQ2
		end
	end

endmodule

// >>> verification/fpu_csr_checker_properties.sv
`include "fpu_csr_map.vh"
module fpu_csr_checker (
	input logic        clk_sys_i,
	input logic        rst_i,
	input logic        coproc_mode_i,
	input logic [7:0]  s_axi_araddr_i,
	input logic        s_axi_arvalid_i,
	input logic        s_axi_arready_o,
	input logic [31:0] s_axi_rdata_o,
	input logic [1:0]  s_axi_rresp_o,
	input logic        s_axi_rvalid_o,
	input logic [10:0] exc_raw_i,
	input logic        move_bit1_i,
	input logic        move_indirect_i,
	input logic        code_access_i,
	input logic        mem_access_i,
	input logic        strobe_oe_o,
	input logic        local_bus_oe_o,
	input logic        coproc_interrupt_out_n_o,
	input logic        memory_chip_enable_n_o,
	input logic        space_select_o,
	input logic [31:0] config_o,
	input logic        enabled_exception_any_o
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [1:0] up_reg;
	reg [7:0] rd_addr_reg;
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// ****************
	// helpers
	// ****************
	// settle count keeps checks off values from inside reset
	always @(posedge clk_sys_i) begin
		if (rst_i)
			up_reg <= 2'h0;
		else if (up_reg != 2'h3)
			up_reg <= up_reg + 2'h1;
	end
	// read address kept for the data phase
	always @(posedge clk_sys_i) begin
		if (s_axi_arvalid_i && s_axi_arready_o)
			rd_addr_reg <= s_axi_araddr_i;
	end
	// ****************
	// properties
	// ****************
	AST_CFG_RST: assert property ($past(rst_i) |-> config_o == `CONFIG_RESET)
		else $error("config not at reset value");
	AST_CFG_ZERO: assert property (config_o[20:11] == 10'h000 && !config_o[7])
		else $error("reserved config bits set");
	AST_ED: assert property ((up_reg == 2'h3 && $stable(exc_raw_i) && $stable(config_o)) [*3]
		|-> enabled_exception_any_o == |(exc_raw_i & config_o[31:21]))
		else $error("exception summary wrong");
	AST_OE: assert property ((up_reg == 2'h3 && !config_o[9]) [*2]
		|-> strobe_oe_o && local_bus_oe_o)
		else $error("strobes released while pin config low");
	AST_SPACE: assert property ((up_reg == 2'h3 && !config_o[8] && mem_access_i
		&& !move_indirect_i && $stable(code_access_i)) [*2]
		|-> space_select_o == !code_access_i && !memory_chip_enable_n_o)
		else $error("space select wrong");
	AST_IRQ_N: assert property ((up_reg == 2'h3 && !coproc_mode_i && config_o[9]
		&& !move_bit1_i) [*2] |-> coproc_interrupt_out_n_o)
		else $error("interrupt out active without move");
	AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	AST_SLVERR: assert property (s_axi_rvalid_o && rd_addr_reg > 8'h20
		|-> s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == 32'h0)
		else $error("unmapped read not refused");
	AST_VEC16: assert property (s_axi_rvalid_o && rd_addr_reg == `OFS_VECTOR
		|-> !s_axi_rdata_o[16])
		else $error("vector bit 16 high");
endmodule
bind fpu_control_status_regs fpu_csr_checker i_fpu_csr_checker (.clk_sys_i, .rst_i,
	.coproc_mode_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .exc_raw_i, .move_bit1_i, .move_indirect_i,
	.code_access_i, .mem_access_i,
	.strobe_oe_o, .local_bus_oe_o, .coproc_interrupt_out_n_o, .memory_chip_enable_n_o,
	.space_select_o, .config_o, .enabled_exception_any_o);

// >>> verification/fpu_control_status_regs_tb_top.sv
`include "fpu_csr_map.vh"
module fpu_control_status_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i, rst_i, coproc_mode_i, s_axi_awvalid_i, s_axi_wvalid_i;
	logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, status_upd_i;
	logic        soft_irq_set_i, hard_irq_set_i, sub_push_i, irq_take_i;
	logic        local_output_enable_i, code_access_i, mem_access_i;
	logic        sub_pop_i, move_bit1_i, move_indirect_i;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, status_core_i, w, v, rdat;
	logic [10:0] exc_raw_i;
	logic [16:0] pc_i, pa, pc;
	logic [1:0]  rsp;
	wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	wire         s_axi_rvalid_o, strobe_oe_o, local_bus_oe_o, coproc_interrupt_out_n_o;
	wire         memory_chip_enable_n_o, space_select_o, enabled_exception_any_o;
	wire [1:0]   s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0]  s_axi_rdata_o, config_o;
	wire [16:0]  return_addr_o;
	integer      seed = 49981, errors = 0, n_compared = 0, cyc = 0, i;

	fpu_control_status_regs i_fpu_control_status_regs (.clk_sys_i, .rst_i, .coproc_mode_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
		.s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
		.exc_raw_i, .status_upd_i, .status_core_i, .soft_irq_set_i, .hard_irq_set_i,
		.sub_push_i, .sub_pop_i, .irq_take_i, .pc_i, .move_bit1_i,
		.move_indirect_i, .local_output_enable_i, .code_access_i, .mem_access_i,
		.strobe_oe_o, .local_bus_oe_o, .coproc_interrupt_out_n_o, .memory_chip_enable_n_o,
		.space_select_o, .return_addr_o, .config_o, .enabled_exception_any_o);

	// ****************
	// bus and check tasks
	// ****************
	task chk(input [31:0] g, input [31:0] e, input [31:0] m);
		n_compared = n_compared + 1;
		if ((g & m) !== (e & m)) begin
			errors = errors + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// address and data offered together, each dropped once taken
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk_sys_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		rsp = s_axi_bresp_o;
	endtask
	task rd(input [7:0] a);
		@(posedge clk_sys_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
		rdat = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
	endtask
	// one-cycle core event pulses, pc presented alongside
	task ev(input [4:0] s, input [16:0] p);
		@(posedge clk_sys_i);
		{status_upd_i, soft_irq_set_i, hard_irq_set_i, sub_push_i, irq_take_i} <= s;
		pc_i <= p;
		@(posedge clk_sys_i);
		{status_upd_i, soft_irq_set_i, hard_irq_set_i, sub_push_i, irq_take_i} <= 5'h0;
	endtask
	task rst_run(input m);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		coproc_mode_i <= m;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	endtask
	task fin(input string s);
		$display("test %s end, errors %0d", s, errors);
	endtask
	task conclude;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************
	// clock, watchdog, sequence
	// ****************
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	// a hung handshake would stall forever, so cap the run
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			$display("CHECK FAILED t=%0t timeout", $time);
			conclude();
		end
	end
	initial begin
		{coproc_mode_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i,
			s_axi_rready_i, status_upd_i, soft_irq_set_i, hard_irq_set_i, sub_push_i,
			irq_take_i, local_output_enable_i, code_access_i, mem_access_i, s_axi_awaddr_i,
			s_axi_araddr_i, s_axi_wdata_i, status_core_i, exc_raw_i, pc_i, sub_pop_i,
			move_bit1_i, move_indirect_i} = '0;
		rst_i = 1'b1;
		rst_run(1'b1);
		rd(`OFS_CONFIG);
		chk(rdat, `CONFIG_RESET, '1);
		rd(`OFS_STATUS);
		chk(rdat, 32'h1000, '1);
		rd(`OFS_INDIRECT);
		chk(rdat, 32'h0, '1);
		fin("reset");
		// bit 7 kept clear, software owes zero there
		for (i = 0; i < 8; i = i + 1) begin
			w = $random(seed);
			w[1:0] = i[1:0];
			w[7] = 1'b0;
			wr(`OFS_CONFIG, w);
			rd(`OFS_CONFIG);
			v = (w & `CONFIG_WMASK) | (`CONFIG_RESET & ~`CONFIG_WMASK);
			chk(rdat, v, '1);
			chk(config_o, v, '1);
		end
		for (i = 0; i < 11; i = i + 1) begin
			@(posedge clk_sys_i);
			exc_raw_i <= 11'h1 << i;
			wr(`OFS_CONFIG, `CONFIG_RESET);
			rd(`OFS_STATUS);
			chk(rdat, 32'h40000, 32'h40000);
			chk({31'h0, enabled_exception_any_o}, 32'h1, 32'h1);
			wr(`OFS_CONFIG, `CONFIG_RESET & ~(32'h200000 << i));
			rd(`OFS_STATUS);
			chk(rdat, 32'h0, 32'h40000);
		end
		@(posedge clk_sys_i);
		exc_raw_i <= 11'h0;
		fin("config");
		w = $random(seed);
		wr(`OFS_STATUS, w);
		rd(`OFS_STATUS);
		chk(rdat, w & `ST_WMASK, '1);
		v = $random(seed);
		status_core_i <= v;
		ev(5'h10, 17'h0);
		rd(`OFS_STATUS);
		chk(rdat, (v & 32'hfffa67e0) | (w & `ST_WMASK), '1);
		ev(5'h0c, 17'h0);
		rd(`OFS_STATUS);
		chk(rdat, 32'h10010, 32'h10010);
		fin("status");
		pa = $random(seed);
		pc = $random(seed);
		ev(5'h02, pa);
		ev(5'h02, ~pa);
		ev(5'h02, pc);
		rd(`OFS_STACK0);
		chk(rdat, {15'h0, pa}, 32'h8001ffff);
		rd(`OFS_STACK1);
		chk(rdat, {1'b1, 14'h0, pc}, 32'h8001ffff);
		// two pops: newest entry comes back first, then the older one
		for (i = 0; i < 2; i = i + 1) begin
			@(posedge clk_sys_i);
			sub_pop_i <= 1'b1;
			@(posedge clk_sys_i);
			sub_pop_i <= 1'b0;
			@(posedge clk_sys_i);
			chk({15'h0, return_addr_o}, {15'h0, (i == 0) ? pc : pa}, 32'h1ffff);
		end
		wr(`OFS_STACK0, 32'h80000000);
		rd(`OFS_STACK0);
		chk(rdat, 32'h0, 32'h80000000);
		wr(`OFS_STACK0, 32'hc0000000);
		rd(`OFS_STACK0);
		chk(rdat, 32'h80000000, 32'h80000000);
		ev(5'h01, pc);
		rd(`OFS_IRQ_RET);
		chk(rdat, {15'h0, pc}, 32'h1ffff);
		chk({15'h0, return_addr_o}, {15'h0, pc}, 32'h1ffff);
		wr(`OFS_VECTOR, 32'hffffffff);
		rd(`OFS_VECTOR);
		chk(rdat, 32'h0, 32'h10000);
		rd(8'h40);
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR}, 32'h3);
		wr(8'h44, $random(seed));
		chk({30'h0, rsp}, {30'h0, `RESP_SLVERR}, 32'h3);
		fin("stack");
		rst_run(1'b0);
		rd(`OFS_IRQ_RET);
		chk(rdat, {15'h0, pc}, 32'h1ffff);
		rd(`OFS_STATUS);
		chk(rdat, 32'h0, '1);
		rd(`OFS_VECTOR);
		chk(rdat, 32'h0, '1);
		wr(`OFS_CONFIG, `CONFIG_RESET | 32'h300);
		local_output_enable_i <= 1'b1;
		mem_access_i <= 1'b1;
		code_access_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		chk({30'h0, strobe_oe_o, local_bus_oe_o}, 32'h0, 32'h3);
		chk({31'h0, memory_chip_enable_n_o}, 32'h0, 32'h1);
		chk({31'h0, coproc_interrupt_out_n_o}, 32'h1, 32'h1);
		code_access_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, memory_chip_enable_n_o}, 32'h1, 32'h1);
		move_bit1_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, coproc_interrupt_out_n_o}, 32'h0, 32'h1);
		move_bit1_i <= 1'b0;
		wr(`OFS_CONFIG, `CONFIG_RESET);
		repeat (2) @(posedge clk_sys_i);
		chk({30'h0, strobe_oe_o, local_bus_oe_o}, 32'h3, 32'h3);
		chk({31'h0, space_select_o}, 32'h1, 32'h1);
		// indirect move: address bit 16 picks data space over the code strobe
		wr(`OFS_INDIRECT, 32'h00010000);
		code_access_i <= 1'b1;
		move_indirect_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		chk({31'h0, space_select_o}, 32'h1, 32'h1);
		fin("pins");
		conclude();
	end
endmodule
